// ==== rtl/atc_timer_block.sv ====
// Core timer with two auxiliary timers, toggle latch, request flags and APB registers.
// Assumes an APB master on pclk; pins are asynchronous to pclk.
//
// Local design decision: the APB register port.
`timescale 1ns/1ns
`include "atc_defines.svh"
module atc_timer_block #(
  parameter int TW = `ATC_TW
) (
  input  wire logic                   pclk,                 // Bus clock, 50 MHz
  input  wire logic                   presetn,              // Async reset, active low
  input  wire logic                   psel,                 // APB select
  input  wire logic                   penable,              // APB enable
  input  wire logic                   pwrite,               // APB write
  input  wire logic [`ATC_ADDR_W-1:0] paddr,                // APB byte address
  input  wire logic [31:0]            pwdata,               // APB write data
  output logic      [31:0]            prdata,               // APB read data
  output logic                        pready,               // APB ready
  output logic                        pslverr,              // APB error, unmapped
  input  wire logic                   core_input_pin,       // Core count or gate pin
  input  wire logic                   aux_input_pin_first,  // First aux pin
  input  wire logic                   aux_input_pin_second, // Second aux pin
  output logic                        first_aux_vector,     // First aux interrupt
  output logic                        core_vector,          // Core interrupt
  output logic                        second_aux_vector     // Second aux interrupt
);

  localparam logic [15:0] IC_IDX [3] = '{`ATC_IDX_AUX0_IC, `ATC_IDX_CORE_IC, `ATC_IDX_AUX1_IC};
  localparam logic [15:0] VAL_IDX [2] = '{`ATC_IDX_AUX0_VAL, `ATC_IDX_AUX1_VAL};
  localparam logic [15:0] CTRL_IDX [2] = '{`ATC_IDX_AUX0_CTRL, `ATC_IDX_AUX1_CTRL};

  // Bus state
  logic [31:0]   next_prdata;
  logic          next_pready;
  logic          next_pslverr;
  logic          wr_go;
  logic [15:0]   idx;

  // Timer state
  logic [7:0]    core_ctrl;
  logic [7:0]    next_core_ctrl;
  logic          core_otl;
  logic          next_core_otl;
  logic [TW-1:0] core_timer;
  logic [TW-1:0] next_core_timer;
  logic [7:0]    aux_ctrl [2];
  logic [7:0]    next_aux_ctrl [2];
  logic [7:0]    irq_ctrl [3];
  logic [7:0]    next_irq_ctrl [3];
  logic [2:0]    irq_line;
  logic [2:0]    next_irq_line;

  // Pin synchronisers
  logic [2:0]    pin_raw;
  logic [2:0]    sync1;
  logic [2:0]    sync2;
  logic [2:0]    sync3;
  logic [2:0]    pin_rise;
  logic [2:0]    pin_fall;

  // Internal events
  atc_pkg::atc_mode_t core_mode;
  logic          core_step;
  logic          core_ovf;
  logic          otl_rise;
  logic          otl_fall;
  logic [TW-1:0] aux_value [2];
  logic [1:0]    reload_req;
  logic [1:0]    aux_flag;
  logic [2:0]    flag_set;

  function automatic logic wr_hit(input logic go, input logic [15:0] a, input logic [15:0] k);
    return go && (a == k);
  endfunction

  assign idx     = paddr[`ATC_IDX_HI:`ATC_IDX_LO];
  assign wr_go   = psel & penable & pwrite & pready;
  assign pin_raw = {aux_input_pin_second, core_input_pin, aux_input_pin_first};

  // Two flops ahead of any logic; a third sample feeds the edge compare
  generate
    for (genvar p = 0; p < 3; p++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sync1[p] <= 1'b0;
          sync2[p] <= 1'b0;
          sync3[p] <= 1'b0;
        end else begin
          sync1[p] <= pin_raw[p];
          sync2[p] <= sync1[p];
          sync3[p] <= sync2[p];
        end
      end
      assign pin_rise[p] = sync2[p] & ~sync3[p];
      assign pin_fall[p] = ~sync2[p] & sync3[p];
    end
  endgenerate

  // APB: one wait state, answer registered
  always_comb begin
    next_pready  = psel & penable & ~pready;
    next_prdata  = prdata;
    next_pslverr = 1'b0;
    if (next_pready) begin
      next_prdata = '0;
      case (idx)
        `ATC_IDX_AUX0_CTRL: next_prdata = 32'(aux_ctrl[0]);
        `ATC_IDX_CORE_CTRL: next_prdata = 32'({core_otl, 1'b0, core_ctrl});
        `ATC_IDX_AUX1_CTRL: next_prdata = 32'(aux_ctrl[1]);
        `ATC_IDX_AUX0_VAL:  next_prdata = 32'(aux_value[0]);
        `ATC_IDX_CORE_VAL:  next_prdata = 32'(core_timer);
        `ATC_IDX_AUX1_VAL:  next_prdata = 32'(aux_value[1]);
        `ATC_IDX_AUX0_IC:   next_prdata = 32'(irq_ctrl[0]);
        `ATC_IDX_CORE_IC:   next_prdata = 32'(irq_ctrl[1]);
        `ATC_IDX_AUX1_IC:   next_prdata = 32'(irq_ctrl[2]);
        default:            next_pslverr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata  <= next_prdata;
      pready  <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // Core timer and its toggle latch
  always_comb begin
    core_mode = atc_pkg::atc_mode_t'(core_ctrl[`ATC_F_MODE]);
    core_step = 1'b0;
    case (core_mode)
      atc_pkg::atc_mode_timer:     core_step = core_ctrl[`ATC_B_RUN];
      atc_pkg::atc_mode_counter:   core_step = core_ctrl[`ATC_B_RUN] &
                                     atc_pkg::atc_edge_hit(core_ctrl[`ATC_F_SEL], pin_rise[1], pin_fall[1],
                                                           1'b0, 1'b0);
      atc_pkg::atc_mode_gate_low:  core_step = core_ctrl[`ATC_B_RUN] & ~sync2[1];
      atc_pkg::atc_mode_gate_high: core_step = core_ctrl[`ATC_B_RUN] & sync2[1];
      default:                     core_step = 1'b0;
    endcase
    core_ovf = core_step & (core_ctrl[`ATC_B_DOWN] ? (core_timer == '0) : (core_timer == '1));
    next_core_timer = core_timer;
    if (core_step) begin
      next_core_timer = core_ctrl[`ATC_B_DOWN] ? core_timer - 1'b1 : core_timer + 1'b1;
    end
    // Second aux overrides the first when both fire together
    if (reload_req[1]) begin
      next_core_timer = aux_value[1];
    end else if (reload_req[0]) begin
      next_core_timer = aux_value[0];
    end
    if (wr_hit(wr_go, idx, `ATC_IDX_CORE_VAL)) begin
      next_core_timer = pwdata[TW-1:0];
    end
    next_core_ctrl = core_ctrl;
    next_core_otl  = core_otl;
    if (wr_hit(wr_go, idx, `ATC_IDX_CORE_CTRL)) begin
      next_core_ctrl = pwdata[`ATC_F_CTRL];
      next_core_otl  = pwdata[`ATC_B_TOGGLE];
    end
    if (core_ovf) begin
      next_core_otl = ~core_otl;
    end
  end

  // Software writes to the latch never reach the aux timers
  assign otl_rise = core_ovf & ~core_otl;
  assign otl_fall = core_ovf & core_otl;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_ctrl  <= `ATC_RST_CTRL;
      core_otl   <= 1'b0;
      core_timer <= '0;
    end else begin
      core_ctrl  <= next_core_ctrl;
      core_otl   <= next_core_otl;
      core_timer <= next_core_timer;
    end
  end

  generate
    for (genvar g = 0; g < 2; g++) begin : g_aux
      atc_aux_unit #(
        .TW(TW)
      ) u_aux (
        .pclk       (pclk),
        .presetn    (presetn),
        .mode       (atc_pkg::atc_mode_t'(aux_ctrl[g][`ATC_F_MODE])),
        .edge_sel   (aux_ctrl[g][`ATC_F_SEL]),
        .run        (aux_ctrl[g][`ATC_B_RUN]),
        .count_down (aux_ctrl[g][`ATC_B_DOWN]),
        .pin_level  (sync2[2*g]),
        .pin_rise   (pin_rise[2*g]),
        .pin_fall   (pin_fall[2*g]),
        .otl_rise   (otl_rise),
        .otl_fall   (otl_fall),
        .core_value (core_timer),
        .wr_value   (wr_hit(wr_go, idx, VAL_IDX[g])),
        .wr_data    (pwdata[TW-1:0]),
        .value      (aux_value[g]),
        .reload_req (reload_req[g]),
        .flag_set   (aux_flag[g])
      );
    end
  endgenerate

  // Request flags and interrupt lines
  // A latch-triggered reload coincides with a core wrap, so the core flag rises too
  assign flag_set = {aux_flag[1], core_ovf, aux_flag[0]};

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      next_aux_ctrl[i] = aux_ctrl[i];
      if (wr_hit(wr_go, idx, CTRL_IDX[i])) begin
        next_aux_ctrl[i] = pwdata[`ATC_F_CTRL];
      end
    end
    for (int i = 0; i < 3; i++) begin
      next_irq_ctrl[i] = irq_ctrl[i];
      if (wr_hit(wr_go, idx, IC_IDX[i])) begin
        next_irq_ctrl[i] = pwdata[`ATC_F_IC];
      end
      if (flag_set[i]) begin
        next_irq_ctrl[i][`ATC_B_IR] = 1'b1;
      end
      next_irq_line[i] = next_irq_ctrl[i][`ATC_B_IR] & next_irq_ctrl[i][`ATC_B_IE];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aux_ctrl[0] <= `ATC_RST_CTRL;
      aux_ctrl[1] <= `ATC_RST_CTRL;
      irq_ctrl[0] <= `ATC_RST_IC;
      irq_ctrl[1] <= `ATC_RST_IC;
      irq_ctrl[2] <= `ATC_RST_IC;
      irq_line    <= 3'h0;
    end else begin
      aux_ctrl[0] <= next_aux_ctrl[0];
      aux_ctrl[1] <= next_aux_ctrl[1];
      irq_ctrl[0] <= next_irq_ctrl[0];
      irq_ctrl[1] <= next_irq_ctrl[1];
      irq_ctrl[2] <= next_irq_ctrl[2];
      irq_line    <= next_irq_line;
    end
  end

  assign first_aux_vector  = irq_line[0];
  assign core_vector       = irq_line[1];
  assign second_aux_vector = irq_line[2];

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_both_edge_count: assert property ((aux_ctrl[0][`ATC_F_MODE] == atc_pkg::atc_mode_counter) &&
                                        (aux_ctrl[0][`ATC_F_SEL] == `ATC_SEL_BOTH_OTL) && aux_ctrl[0][`ATC_B_RUN]
                                        && core_ovf && !wr_go |=> aux_value[0] != $past(aux_value[0]))
    else $error("aux timer missed a core wrap");
  chk_latch_needs_wrap: assert property (reload_req[0] && aux_ctrl[0][`ATC_B_SEL_HI] |-> core_ovf)
    else $error("latch reload without core wrap");
  chk_reload_first: assert property (reload_req[0] && !reload_req[1] && !wr_go
                                     |=> core_timer == $past(aux_value[0]) && irq_ctrl[0][`ATC_B_IR])
    else $error("reload from first aux failed");
  chk_reload_priority: assert property (reload_req[0] && reload_req[1] && !wr_go
                                        |=> core_timer == $past(aux_value[1]))
    else $error("second aux did not win reload");
  chk_core_wrap_flag: assert property (core_ovf |=> irq_ctrl[1][`ATC_B_IR] && core_otl != $past(core_otl))
    else $error("core wrap did not set flag or toggle");
  chk_irq_gate: assert property (core_vector == (irq_ctrl[1][`ATC_B_IR] && irq_ctrl[1][`ATC_B_IE]))
    else $error("core interrupt not gated by enable");
  chk_set_wins: assert property (flag_set[1] && wr_hit(wr_go, idx, `ATC_IDX_CORE_IC) && !pwdata[`ATC_B_IR]
                                 |=> irq_ctrl[1][`ATC_B_IR])
    else $error("software clear beat hardware set");
  chk_pin_edge_delay: assert property (pin_rise[0] |-> $past(pin_raw[0], 2) && !$past(pin_raw[0], 3))
    else $error("pin edge not from synchronised samples");
  chk_pin_fall_delay: assert property (pin_fall[2] |-> !$past(pin_raw[2], 2) && $past(pin_raw[2], 3))
    else $error("pin fall not from synchronised samples");
  // Software latch writes must leave latch-clocked aux timers alone
  chk_sw_latch_quiet: assert property (
    (aux_ctrl[0][`ATC_F_MODE] == atc_pkg::atc_mode_counter) && aux_ctrl[0][`ATC_B_SEL_HI] && !core_ovf
    && !wr_hit(wr_go, idx, `ATC_IDX_AUX0_VAL) |=> $stable(aux_value[0]))
    else $error("aux timer moved on software latch write");
  chk_toggle_only_wrap: assert property (
    !core_ovf && !wr_hit(wr_go, idx, `ATC_IDX_CORE_CTRL) |=> $stable(core_otl))
    else $error("toggle latch moved without wrap or write");
  chk_reload_second: assert property (reload_req[1] && !wr_go
                                      |=> core_timer == $past(aux_value[1]) && irq_ctrl[2][`ATC_B_IR])
    else $error("reload from second aux failed");
  chk_aux_flag_first: assert property (aux_flag[0] |=> irq_ctrl[0][`ATC_B_IR])
    else $error("first aux event did not set its flag");
  chk_aux_flag_second: assert property (aux_flag[1] |=> irq_ctrl[2][`ATC_B_IR])
    else $error("second aux event did not set its flag");
  chk_gate_hold: assert property (
    (core_mode == atc_pkg::atc_mode_gate_high) && !sync2[1] && !(|reload_req)
    && !wr_hit(wr_go, idx, `ATC_IDX_CORE_VAL) |=> $stable(core_timer))
    else $error("gated core counted with gate closed");
  // Bus handshake: exactly one wait state, answer stands one cycle
  chk_apb_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("access not answered after one wait");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("ready stood longer than one cycle");
  chk_err_with_ready: assert property (pslverr |-> pready)
    else $error("error response without ready");

endmodule

// ==== rtl/atc_defines.svh ====
// Constants of the auxiliary timer block: register indices, field positions, reset values.
// Assumes it is included once per file by its bare name.
`ifndef ATC_DEFINES_SVH
`define ATC_DEFINES_SVH

`define ATC_TW            16
`define ATC_ADDR_W        18
`define ATC_IDX_HI        17
`define ATC_IDX_LO        2

`define ATC_IDX_AUX0_CTRL 16'hff40
`define ATC_IDX_CORE_CTRL 16'hff42
`define ATC_IDX_AUX1_CTRL 16'hff44
`define ATC_IDX_AUX0_VAL  16'hfe40
`define ATC_IDX_CORE_VAL  16'hfe42
`define ATC_IDX_AUX1_VAL  16'hfe44
`define ATC_IDX_AUX0_IC   16'hff60
`define ATC_IDX_CORE_IC   16'hff62
`define ATC_IDX_AUX1_IC   16'hff64

`define ATC_F_SEL         2:0
`define ATC_F_SEL_LOW     1:0
`define ATC_B_SEL_HI      2
`define ATC_F_MODE        5:3
`define ATC_B_RUN         6
`define ATC_B_DOWN        7
`define ATC_F_CTRL        7:0
`define ATC_B_TOGGLE      9
`define ATC_B_IR          7
`define ATC_B_IE          6
`define ATC_F_IC          7:0

`define ATC_RST_CTRL      8'h00
`define ATC_RST_IC        8'h00
`define ATC_SEL_BOTH_OTL  3'h7
`define ATC_SEL_RISE_OTL  3'h5

`endif

// ==== rtl/atc_pkg.sv ====
// Types and shared decoding of the auxiliary timer block.
// Assumes nothing of its surroundings.
package atc_pkg;

  typedef enum logic [2:0] {
    atc_mode_timer,
    atc_mode_counter,
    atc_mode_gate_low,
    atc_mode_gate_high,
    atc_mode_reload,
    atc_mode_capture,
    atc_mode_incr,
    atc_mode_rsvd
  } atc_mode_t;

  // Edge select decode, shared by counter, reload and capture paths
  function automatic logic atc_edge_hit(input logic [2:0] sel,
                                        input logic       pin_rise,
                                        input logic       pin_fall,
                                        input logic       otl_rise,
                                        input logic       otl_fall);
    logic hit;
    hit = 1'b0;
    case (sel)
      3'h1:    hit = pin_rise;
      3'h2:    hit = pin_fall;
      3'h3:    hit = pin_rise | pin_fall;
      3'h5:    hit = otl_rise;
      3'h6:    hit = otl_fall;
      3'h7:    hit = otl_rise | otl_fall;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction

endpackage

// ==== rtl/atc_aux_unit.sv ====
// One auxiliary timer: counting, reload request and capture.
// Assumes pin edges are already synchronised and toggle events come only from core wraps.
`timescale 1ns/1ns
`include "atc_defines.svh"
module atc_aux_unit #(
  parameter int TW = `ATC_TW
) (
  input  wire logic              pclk,        // Bus clock
  input  wire logic              presetn,     // Async reset, active low
  input  atc_pkg::atc_mode_t     mode,        // Operating mode
  input  wire logic [2:0]        edge_sel,    // Edge select field
  input  wire logic              run,         // Run bit
  input  wire logic              count_down,  // Direction, 1 counts down
  input  wire logic              pin_level,   // Synchronised pin level
  input  wire logic              pin_rise,    // Pin rising edge pulse
  input  wire logic              pin_fall,    // Pin falling edge pulse
  input  wire logic              otl_rise,    // Core toggle rise from wrap
  input  wire logic              otl_fall,    // Core toggle fall from wrap
  input  wire logic [TW-1:0]     core_value,  // Core timer value
  input  wire logic              wr_value,    // Software writes value
  input  wire logic [TW-1:0]     wr_data,     // Value to write
  output logic [TW-1:0]          value,       // Timer register
  output logic                   reload_req,  // Reload the core now
  output logic                   flag_set     // Set this timer's flag
);

  logic [TW-1:0] next_value;
  logic          step;
  logic          trig;
  logic          cap;

  always_comb begin
    next_value = value;
    reload_req = 1'b0;
    flag_set   = 1'b0;
    step       = 1'b0;
    trig       = atc_pkg::atc_edge_hit(edge_sel, pin_rise, pin_fall, otl_rise, otl_fall);
    cap        = atc_pkg::atc_edge_hit({1'b0, edge_sel[`ATC_F_SEL_LOW]}, pin_rise, pin_fall, 1'b0, 1'b0);
    case (mode)
      atc_pkg::atc_mode_timer:     step = run;
      atc_pkg::atc_mode_counter:   step = run & trig;
      atc_pkg::atc_mode_gate_low:  step = run & ~pin_level;
      atc_pkg::atc_mode_gate_high: step = run & pin_level;
      atc_pkg::atc_mode_reload: begin
        reload_req = trig;
        flag_set   = trig;
      end
      atc_pkg::atc_mode_capture: begin
        if (cap) begin
          next_value = core_value;
        end
        flag_set = cap;
      end
      default:                     step = 1'b0;
    endcase
    if (step) begin
      // Direction is this timer's own, the core may run the other way
      if (count_down) begin
        next_value = value - 1'b1;
        flag_set   = (value == '0);
      end else begin
        next_value = value + 1'b1;
        flag_set   = (value == '1);
      end
    end
    if (wr_value) begin
      next_value = wr_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      value <= '0;
    end else begin
      value <= next_value;
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_reload_frozen: assert property ((mode == atc_pkg::atc_mode_reload) && !wr_value |=> $stable(value))
    else $error("aux timer moved in reload mode");
  chk_capture_core: assert property ((mode == atc_pkg::atc_mode_capture) && cap && !wr_value
                                     |=> value == $past(core_value))
    else $error("capture did not latch core value");
  chk_single_edge: assert property ((mode == atc_pkg::atc_mode_counter) && (edge_sel == `ATC_SEL_RISE_OTL)
                                    && otl_fall && !wr_value |=> $stable(value))
    else $error("single edge counter moved on other edge");

endmodule

// ==== testbench/atc_testbench.sv ====
// Self-checking bench of the auxiliary timer block: APB register traffic and pin stimulus.
// Assumes the block answers each APB access with one wait cycle; pins are driven at pclk edges.
`timescale 1ns/1ns
`include "atc_defines.svh"
module testbench;
  typedef struct packed {logic [31:0] data; logic err;} atc_exp_t;
  logic                   pclk, presetn, psel, penable, pwrite;
  logic [`ATC_ADDR_W-1:0] paddr;
  logic [31:0]            pwdata, prdata, rnd;
  logic                   pready, pslverr, core_pin, aux_pin0, aux_pin1;
  logic [2:0]             vec;
  atc_exp_t               expq[$];
  atc_exp_t               e;
  int                     fails, total_checks;
  logic [15:0]            ic_idx[3] = '{`ATC_IDX_AUX0_IC, `ATC_IDX_CORE_IC, `ATC_IDX_AUX1_IC};

  atc_timer_block #(.TW(16)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .core_input_pin(core_pin), .aux_input_pin_first(aux_pin0), .aux_input_pin_second(aux_pin1),
    .first_aux_vector(vec[0]), .core_vector(vec[1]), .second_aux_vector(vec[2]));

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Request held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [15:0] idx, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [15:0] idx, input logic [31:0] d);
    apb(1'b1, idx, d);
  endtask

  task automatic rd(input logic [15:0] idx, input logic [31:0] x, input logic err = 1'b0);
    expq.push_back('{x, err});
    apb(1'b0, idx, 32'h0);
  endtask

  task automatic check(input logic ok, input string msg);
    total_checks++;
    if (!ok) begin
      fails++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask

  // Pins kept at each level for ten clocks, well beyond the three synchroniser stages
  task automatic pulse(input int which);
    @(posedge pclk);
    case (which)
      0: aux_pin0 <= 1'b1;
      1: aux_pin1 <= 1'b1;
      default: core_pin <= 1'b1;
    endcase
    repeat (10) @(posedge pclk);
    aux_pin0 <= 1'b0;
    aux_pin1 <= 1'b0;
    core_pin <= 1'b0;
    repeat (10) @(posedge pclk);
  endtask

  // Read results are compared against the oldest note
  always @(posedge pclk) begin
    if (psel && penable && !pwrite && pready === 1'b1) begin
      e = expq.pop_front();
      check(prdata === e.data && pslverr === e.err, "read data or error response");
    end
  end

  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    close_out();
  end

  initial begin
    {presetn, psel, penable, pwrite, core_pin, aux_pin0, aux_pin1} = 7'h0;
    paddr = '0;
    pwdata = 32'h0;
    rnd = 32'h7b82;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd(`ATC_IDX_CORE_IC, 32'h0);
    rd(`ATC_IDX_AUX0_CTRL, 32'h0);
    rd(16'h0123, 32'h0, 1'b1);
    // Concatenation: first aux both edges up, second aux rising edge down
    wr(`ATC_IDX_AUX0_CTRL, 32'h4f);
    wr(`ATC_IDX_AUX1_CTRL, 32'hcd);
    wr(`ATC_IDX_CORE_CTRL, 32'h40);
    for (int i = 0; i < 4; i++) begin
      wr(`ATC_IDX_CORE_VAL, 32'hfffe);
      repeat (10) @(posedge pclk);
    end
    wr(`ATC_IDX_CORE_CTRL, 32'h0);
    rd(`ATC_IDX_AUX0_VAL, 32'h4);
    rd(`ATC_IDX_AUX1_VAL, 32'hfffe);
    rd(`ATC_IDX_CORE_IC, 32'h80);
    rd(`ATC_IDX_AUX1_IC, 32'h80);
    rd(`ATC_IDX_AUX0_IC, 32'h0);
    wr(`ATC_IDX_CORE_CTRL, 32'h200);
    repeat (5) @(posedge pclk);
    rd(`ATC_IDX_AUX0_VAL, 32'h4);
    rd(`ATC_IDX_CORE_CTRL, 32'h200);
    for (int i = 0; i < 3; i++) wr(ic_idx[i], 32'h0);
    // Reload: both aux on both latch edges, second one wins
    wr(`ATC_IDX_AUX0_VAL, 32'h1234);
    wr(`ATC_IDX_AUX1_VAL, 32'h5678);
    wr(`ATC_IDX_AUX0_CTRL, 32'h67);
    wr(`ATC_IDX_AUX1_CTRL, 32'h27);
    wr(`ATC_IDX_CORE_CTRL, 32'h49);
    wr(`ATC_IDX_CORE_VAL, 32'hffff);
    pulse(2);
    rd(`ATC_IDX_CORE_VAL, 32'h5678);
    rd(`ATC_IDX_CORE_IC, 32'h80);
    rd(`ATC_IDX_AUX1_IC, 32'h80);
    rd(`ATC_IDX_AUX0_VAL, 32'h1234);
    // Latch now high: falling edge reloads first aux, rising edge second
    wr(`ATC_IDX_AUX0_CTRL, 32'h26);
    wr(`ATC_IDX_AUX1_CTRL, 32'h25);
    for (int k = 0; k < 2; k++) begin
      wr(`ATC_IDX_CORE_VAL, 32'hffff);
      pulse(2);
      rd(`ATC_IDX_CORE_VAL, k ? 32'h5678 : 32'h1234);
    end
    // Capture with select bit 2 set, which must be ignored
    wr(`ATC_IDX_CORE_CTRL, 32'h0);
    for (int u = 0; u < 2; u++) begin
      rnd = lfsr(rnd);
      wr(`ATC_IDX_CORE_VAL, rnd);
      wr(u ? `ATC_IDX_AUX1_CTRL : `ATC_IDX_AUX0_CTRL, u ? 32'h2e : 32'h2d);
      pulse(u);
      rd(u ? `ATC_IDX_AUX1_VAL : `ATC_IDX_AUX0_VAL, {16'h0, rnd[15:0]});
    end
    // Vector follows flag only while enabled
    for (int i = 0; i < 3; i++) begin
      wr(ic_idx[i], 32'hc0);
      repeat (2) @(posedge pclk);
      check(vec[i] === 1'b1, "vector not raised");
      wr(ic_idx[i], 32'h80);
      repeat (2) @(posedge pclk);
      check(vec[i] === 1'b0, "vector raised while disabled");
    end
    // Gated core, then a reload triggered by the first aux pin
    for (int i = 0; i < 3; i++) wr(ic_idx[i], 32'h0);
    wr(`ATC_IDX_CORE_VAL, 32'h0);
    wr(`ATC_IDX_CORE_CTRL, 32'h58);
    pulse(2);
    rd(`ATC_IDX_CORE_VAL, 32'ha);
    wr(`ATC_IDX_AUX0_VAL, 32'h0abc);
    wr(`ATC_IDX_AUX0_CTRL, 32'h21);
    pulse(0);
    rd(`ATC_IDX_CORE_VAL, 32'habc);
    rd(`ATC_IDX_AUX0_IC, 32'h80);
    rd(`ATC_IDX_CORE_IC, 32'h0);
    repeat (5) @(posedge pclk);
    check(expq.size() == 0, "reads left unanswered");
    close_out();
  end
endmodule
